// ### tcou_pins.sv
// Purpose: Pin-side partner driving both trigger/capture pins
// Assumes: Pins change just after a rising edge of ref_clk
// Notes:   Polite calls wait out an active one-shot pulse
`timescale 1ns/1ps
module tcou_pins (
  // Clock and status
  input  wire logic ref_clk,
  input  wire logic oneshot_busy,
  // Pins
  output logic      pin_a,
  output logic      pin_b
);
  // ****************
  // Pin driver
  // ****************
  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
  end
  // Impolite calls exist only to prove that retriggers are ignored
  task automatic drive(input bit sel_b, input bit level, input bit polite);
    for (int i = 0; i < 400 && polite && oneshot_busy !== 1'b0; i++) @(posedge ref_clk);
    @(posedge ref_clk);
    if (sel_b) begin
      pin_b <= level;
    end else begin
      pin_a <= level;
    end
  endtask
endmodule

// ### tcou_pkg.sv
// Purpose: Shared constants, types and the input edge detector of the timer unit
// Assumes: Inputs synchronous to ref_clk
// Notes:   Package first, then the edge detector leaf module
package tcou_pkg;
  // ****************
  // Modes and edges
  // ****************
  localparam logic [1:0]  MODE_STOP      = 2'h0;
  localparam logic [1:0]  MODE_TRIG_CLR  = 2'h1;
  localparam logic [1:0]  MODE_FREE      = 2'h2;
  localparam logic [1:0]  MODE_MATCH_CLR = 2'h3;
  localparam logic [1:0]  EDGE_FALL      = 2'h0;
  localparam logic [1:0]  EDGE_RISE      = 2'h1;
  localparam logic [1:0]  EDGE_NONE      = 2'h2;
  localparam logic [1:0]  EDGE_BOTH      = 2'h3;
  // ****************
  // Counter values
  // ****************
  localparam int          CNT_W          = 16;
  localparam logic [15:0] CNT_ZERO       = 16'h0000;
  localparam logic [15:0] CNT_ONE        = 16'h0001;
  localparam logic [15:0] CNT_MAX        = 16'hFFFF;
  // ****************
  // Count clock
  // ****************
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          COUNT_PERIOD_NS = 100;
  localparam int          DIV_W           = 4;
  localparam logic [3:0]  DIV_LAST = 4'((COUNT_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 1);
  localparam logic [3:0]  DIV_ZERO = 4'h0;
  // ****************
  // Carriers
  // ****************
  typedef struct packed {
    logic capcomp_irq_a;
    logic capcomp_irq_b;
  } tcou_irq_s;
  typedef struct packed {
    logic valid;
    logic reverse;
  } tcou_edge_s;
endpackage

`timescale 1ns/1ps
module tcou_edge
  import tcou_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // Pin and selection
  input  wire logic       pin,
  input  wire logic [1:0] sel,
  // Detected edges
  output tcou_edge_s      edges
);
  logic prev_q;
  logic prev_d;
  logic rise;
  logic fall;

  always_comb begin
    prev_d        = pin;
    rise          = pin & ~prev_q;
    fall          = ~pin & prev_q;
    edges.valid   = 1'b0;
    edges.reverse = 1'b0;
    case (sel)
      EDGE_FALL: begin
        edges.valid   = fall;
        edges.reverse = rise;
      end
      EDGE_RISE: begin
        edges.valid   = rise;
        edges.reverse = fall;
      end
      EDGE_BOTH: begin
        edges.valid   = rise | fall;
      end
      default: begin
        edges.valid   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
    end
  end
endmodule

// ### tcou_tb.sv
// Purpose: Self-checking bench for the timer channel
// Assumes: Channel zero, reset idle output level low
// Notes:   Wrap and overflow need 65536 ticks, too long to run here
`timescale 1ns/1ps
module testbench;
  import tcou_pkg::*;
  // ****************
  // Stimulus and model state
  // ****************
  logic        ref_clk = 1'b0;
  logic        resetn  = 1'b0;
  logic [1:0]  mode    = MODE_STOP;
  logic        cap_a   = 1'b0;
  logic        cap_b   = 1'b0;
  logic        os_en   = 1'b0;
  logic        os_sw   = 1'b0;
  logic        lv_set  = 1'b0;
  logic        lv_rst  = 1'b0;
  logic [1:0]  es_a    = EDGE_RISE;
  logic        wr_a    = 1'b0;
  logic        wr_b    = 1'b0;
  logic        rd_a    = 1'b0;
  logic        rd_b    = 1'b0;
  logic [15:0] wr_data = 16'h0000;
  logic [15:0] cnt, rd_data, prev, cmp_a, cmp_b, exp, got;
  logic        pin_a, pin_b, rd_ok, ovf, os_out, os_busy;
  tcou_irq_s   irq;
  int          fails = 0, num_checks = 0, seed = 55;
  int          n_a = 0, n_b = 0, hi_len = 0, last_hi = 0, cmax = 0, n0;

  tcou_timer #(.CHANNEL_ID(1'b0)) dut (.ref_clk(ref_clk), .resetn(resetn),
    .mode_select_hi(mode[1]), .mode_select_lo(mode[0]), .edge_select_bit0(es_a[0]), .edge_select_bit1(es_a[1]),
    .edge_select_b(EDGE_RISE), .cap_mode_a(cap_a), .cap_mode_b(cap_b), .oneshot_en(os_en),
    .oneshot_sw_trigger(os_sw), .output_level_set(lv_set), .output_level_reset(lv_rst), .wr_a(wr_a),
    .wr_b(wr_b), .wr_data(wr_data), .rd_a(rd_a), .rd_b(rd_b), .overflow_clear(1'b0),
    .trigger_capture_input_a(pin_a), .capture_input_b(pin_b), .count_value_reg(cnt), .rd_data(rd_data),
    .rd_ok(rd_ok), .overflow_flag(ovf), .irq(irq), .oneshot_out(os_out), .oneshot_busy(os_busy));
  tcou_pins pins (.ref_clk(ref_clk), .oneshot_busy(os_busy), .pin_a(pin_a), .pin_b(pin_b));

  always #5 ref_clk = ~ref_clk;

  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic results();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ****************
  // Reference model
  // ****************
  always @(posedge ref_clk) begin
    if (irq.capcomp_irq_a === 1'b1) n_a++;
    if (irq.capcomp_irq_b === 1'b1) n_b++;
    if (os_out === 1'b1) hi_len++;
    else if (hi_len != 0) begin
      last_hi = hi_len;
      hi_len  = 0;
    end
    if (int'(cnt) > cmax) cmax = int'(cnt);
    if (resetn === 1'b1 && cnt !== prev && cnt !== CNT_ZERO) chk("count step", prev + CNT_ONE, cnt);
    prev = cnt;
  end
  // ****************
  // Bus tasks
  // ****************
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input bit sel_b, input logic [15:0] v);
    @(posedge ref_clk);
    wr_data <= v;
    wr_a    <= ~sel_b;
    wr_b    <= sel_b;
    @(posedge ref_clk);
    wr_a    <= 1'b0;
    wr_b    <= 1'b0;
  endtask
  task automatic rd(input bit sel_b, output logic [15:0] v);
    @(posedge ref_clk);
    rd_a <= ~sel_b;
    rd_b <= sel_b;
    @(posedge ref_clk);
    rd_a <= 1'b0;
    rd_b <= 1'b0;
    @(posedge ref_clk);
    v = rd_data;
  endtask
  task automatic sw_shot();
    @(posedge ref_clk);
    os_sw <= 1'b1;
    @(posedge ref_clk);
    os_sw <= 1'b0;
  endtask
  task automatic wait_idle();
    cyc(2);
    for (int i = 0; i < 400 && os_busy !== 1'b0; i++) @(posedge ref_clk);
    cyc(2);
  endtask
  // Edge placed just after a count step, so the count is steady
  task automatic cap(input bit sel_b, input bit level, output logic [15:0] e);
    logic [15:0] c0;
    c0 = cnt;
    for (int i = 0; i < 30 && cnt === c0; i++) @(posedge ref_clk);
    cyc(2);
    e = cnt;
    pins.drive(sel_b, level, 1'b1);
    cyc(5);
  endtask
  // ****************
  // Scenarios
  // ****************
  initial begin
    cyc(8);
    resetn <= 1'b1;
    cyc(30);
    chk("count stopped", CNT_ZERO, cnt);
    chk("flags at reset", 16'h0000, {12'h000, ovf, os_out, os_busy, rd_ok});
    cmp_b = 16'(3 + $unsigned($random(seed)) % 3);
    cmp_a = cmp_b + 16'(3 + $unsigned($random(seed)) % 4);
    wr(1'b1, cmp_b);
    wr(1'b0, cmp_a);
    mode <= MODE_FREE;
    cyc(12);
    chk("started", 16'h0001, 16'(cnt >= 16'h0001 && cnt <= 16'h0002));
    n0 = n_b;
    cyc(int'(cmp_b) * 10 + 20);
    chk("match irq b", 16'h0001, 16'(n_b - n0));
    cap_a <= 1'b1;
    cap_b <= 1'b1;
    // Let a late compare interrupt of reg a drain before counting
    cyc(2);
    n0 = n_a;
    cap(1'b1, 1'b1, exp);
    chk("irq a on valid edge", 16'h0001, 16'(n_a - n0));
    rd(1'b0, got);
    chk("capture a", exp, got);
    chk("read ok", 16'h0001, {15'h0000, rd_ok});
    n0 = n_b;
    cap(1'b0, 1'b1, exp);
    chk("irq b on valid edge", 16'h0001, 16'(n_b - n0));
    rd(1'b1, got);
    chk("capture b", exp, got);
    n0 = n_a;
    cap(1'b0, 1'b0, exp);
    chk("silent reverse edge", 16'h0000, 16'(n_a - n0));
    rd(1'b0, got);
    chk("reverse capture a", exp, got);
    pins.drive(1'b1, 1'b0, 1'b1);
    cyc(2);
    n0 = n_a;
    // Read of reg a lands in the same cycle as its capture
    fork
      pins.drive(1'b1, 1'b1, 1'b1);
      rd(1'b0, got);
    join
    cyc(2);
    chk("clash read flag", 16'h0000, {15'h0000, rd_ok});
    chk("clash irq a", 16'h0001, 16'(n_a - n0));
    cap_a <= 1'b0;
    cap_b <= 1'b0;
    os_en <= 1'b1;
    wr(1'b1, cmp_b);
    wr(1'b0, cmp_a);
    last_hi = 0;
    sw_shot();
    wait_idle();
    chk("sw pulse width", 16'((cmp_a - cmp_b) * 10), 16'(last_hi));
    mode <= MODE_TRIG_CLR;
    last_hi = 0;
    pins.drive(1'b0, 1'b1, 1'b1);
    for (int i = 0; i < 400 && os_out !== 1'b1; i++) @(posedge ref_clk);
    pins.drive(1'b0, 1'b0, 1'b0);
    pins.drive(1'b0, 1'b1, 1'b0);
    wait_idle();
    chk("ext pulse width", 16'((cmp_a - cmp_b) * 10), 16'(last_hi));
    pins.drive(1'b0, 1'b0, 1'b1);
    pins.drive(1'b0, 1'b1, 1'b1);
    cyc(4);
    chk("pin restarts", 16'h0001, 16'(cnt < 16'h0002 && os_busy === 1'b1));
    wait_idle();
    mode <= MODE_STOP;
    cyc(3);
    chk("stop holds zero", CNT_ZERO, cnt);
    mode <= MODE_MATCH_CLR;
    cmax = 0;
    last_hi = 0;
    sw_shot();
    cyc(int'(cmp_a) * 30);
    chk("match clear top", cmp_a, 16'(cmax));
    chk("no pulse in match clear", 16'h0000, 16'(last_hi + hi_len));
    mode <= MODE_STOP;
    cyc(2);
    lv_set <= 1'b1;
    cyc(1);
    lv_set <= 1'b0;
    cyc(3);
    chk("idle level set", 16'h0001, {15'h0000, os_out});
    es_a  <= EDGE_FALL;
    cap_b <= 1'b1;
    cyc(2);
    mode  <= MODE_FREE;
    n0 = n_b;
    cap(1'b0, 1'b0, exp);
    chk("irq b on falling edge", 16'h0001, 16'(n_b - n0));
    rd(1'b1, got);
    chk("capture b on falling edge", exp, got);
    mode  <= MODE_STOP;
    cyc(2);
    lv_rst <= 1'b1;
    cyc(1);
    lv_rst <= 1'b0;
    cyc(3);
    chk("idle level reset", 16'h0000, {15'h0000, os_out});
    results();
  end
  // Whole run is about a thousand cycles
  initial begin
    cyc(20000);
    fails++;
    $display("mismatch watchdog expected done seen hang");
    results();
  end
endmodule

// ### tcou_timer.sv
// Purpose: 16-bit timer/event counter channel with two capture/compare registers and one-shot output
// Assumes: All inputs synchronous to ref_clk; control bits are plain ports
// Notes on behaviour
// RULE1 - Trigger edges do not restart during software one-shot
// RULE2 - Software never loads zero into compare registers
// RULE3 - Nonzero mode starts counting; zero mode stops
// RULE4 - Triggers during one-shot pulse are ignored
// RULE5 - External one-shot trigger only on channel zero
// RULE6 - Software follows output level setup sequence
// RULE7 - First match may slip one count clock
// RULE8 - Match-clear mode needs nonzero compare value
// RULE9 - Read colliding with capture returns undefined value
// RULE10 - Valid edge capture interrupts; reverse edge silent
// RULE11 - Software reads capture after its interrupt
// RULE12 - Registers undefined after stop
// RULE13 - Edge select changed only while stopped
// RULE14 - Partner waits for active level end
// RULE15 - Overflow flag on wrap or FFFF match clear
// RULE16 - Overflow clear ignored until count reaches one
// RULE17 - One-shot unavailable in match-clear mode
// RULE18 - No software trigger during pulse
// RULE19 - Counter wraps FFFF to zero per tick
`timescale 1ns/1ps
module tcou_timer
  import tcou_pkg::*;
#(
  parameter bit CHANNEL_ID = 1'b0
)
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // Mode and edge control
  input  wire logic        mode_select_hi,
  input  wire logic        mode_select_lo,
  input  wire logic        edge_select_bit0,
  input  wire logic        edge_select_bit1,
  input  wire logic [1:0]  edge_select_b,
  input  wire logic        cap_mode_a,
  input  wire logic        cap_mode_b,
  // One-shot control
  input  wire logic        oneshot_en,
  input  wire logic        oneshot_sw_trigger,
  input  wire logic        output_level_set,
  input  wire logic        output_level_reset,
  // Register writes and reads
  input  wire logic        wr_a,
  input  wire logic        wr_b,
  input  wire logic [15:0] wr_data,
  input  wire logic        rd_a,
  input  wire logic        rd_b,
  input  wire logic        overflow_clear,
  // Pins
  input  wire logic        trigger_capture_input_a,
  input  wire logic        capture_input_b,
  // Status and outputs
  output logic [15:0]      count_value_reg,
  output logic [15:0]      rd_data,
  output logic             rd_ok,
  output logic             overflow_flag,
  output tcou_irq_s        irq,
  output logic             oneshot_out,
  output logic             oneshot_busy
);
  // ****************
  // Declarations
  // ****************
  logic [1:0]  mode;
  logic [3:0]  div_q, div_d;
  logic        tick;
  logic [15:0] cnt_q, cnt_d, cap_a_q, cap_a_d, cap_b_q, cap_b_d, rd_q, rd_d;
  logic        ovf_q, ovf_d, hold_q, hold_d, busy_q, busy_d, out_q, out_d, lvl_q, lvl_d;
  logic        rdok_q, rdok_d;
  tcou_irq_s   irq_q, irq_d;
  tcou_edge_s  ea, eb;
  logic        cap_a_evt, cap_b_evt, wrap_evt, os_ok, os_ext, os_start, pulse_end, trig_clr;

  assign mode = {mode_select_hi, mode_select_lo};

  tcou_edge u_edge_a (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .pin     (trigger_capture_input_a),
    .sel     ({edge_select_bit1, edge_select_bit0}),
    .edges   (ea)
  );
  tcou_edge u_edge_b (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .pin     (capture_input_b),
    .sel     (edge_select_b),
    .edges   (eb)
  );

  // ****************
  // Count clock divider
  // ****************
  // Free running, so the first tick after start lands anywhere in a period
  always_comb begin
    tick  = (div_q == DIV_LAST);                                    // see RULE7
    div_d = tick ? DIV_ZERO : 4'(div_q + 4'h1);
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      div_q <= DIV_ZERO;
    end else begin
      div_q <= div_d;
    end
  end

  // ****************
  // Counter, capture, overflow, one-shot
  // ****************
  always_comb begin
    cnt_d     = cnt_q;
    cap_a_d   = cap_a_q;
    cap_b_d   = cap_b_q;
    ovf_d     = ovf_q;
    hold_d    = hold_q;
    busy_d    = busy_q;
    out_d     = out_q;
    lvl_d     = lvl_q;
    irq_d     = '0;
    rd_d      = rd_q;
    rdok_d    = rdok_q;
    wrap_evt  = 1'b0;
    pulse_end = 1'b0;
    // Reverse edge of pin a captures into a without an interrupt
    cap_a_evt = cap_mode_a && mode != MODE_STOP && (eb.valid || ea.reverse);  // see RULE10
    cap_b_evt = cap_mode_b && mode != MODE_STOP && ea.valid;
    os_ok     = oneshot_en && (mode == MODE_FREE || mode == MODE_TRIG_CLR);  // see RULE17
    os_ext    = os_ok && mode == MODE_TRIG_CLR && CHANNEL_ID == 1'b0 && ea.valid;  // see RULE5
    os_start  = !busy_q && (os_ext || (os_ok && oneshot_sw_trigger));   // see RULE4
    // Trigger edges clear the counter only while no one-shot pulse is running
    trig_clr  = mode == MODE_TRIG_CLR && ea.valid && !busy_q;         // see RULE1
    if (mode == MODE_STOP) begin
      // Capture registers are left as they are; a read here still sets rd_ok
      cnt_d  = CNT_ZERO;                                                  // see RULE12
      busy_d = 1'b0;
      hold_d = 1'b0;
      if (output_level_set) begin
        lvl_d = 1'b1;
      end else if (output_level_reset) begin
        lvl_d = 1'b0;
      end
      out_d = lvl_d;
    end else if (os_start || trig_clr) begin
      cnt_d  = CNT_ZERO;                                                  // see RULE3
      busy_d = os_start;
    end else if (tick) begin
      if (mode == MODE_MATCH_CLR && cnt_q == cap_a_q) begin
        // A zero compare clears on every tick, so one event never counts
        cnt_d    = CNT_ZERO;                                              // see RULE8
        wrap_evt = (cnt_q == CNT_MAX);                                    // see RULE15
      end else begin
        cnt_d    = 16'(cnt_q + CNT_ONE);                                  // see RULE19
        wrap_evt = (cnt_q == CNT_MAX);
      end
      if (!cap_mode_a && cnt_q == cap_a_q) begin
        irq_d.capcomp_irq_a = 1'b1;
      end
      if (!cap_mode_b && cnt_q == cap_b_q) begin
        irq_d.capcomp_irq_b = 1'b1;
      end
      if (busy_q && cnt_q == cap_b_q) begin
        out_d = ~lvl_q;
      end
      if (busy_q && cnt_q == cap_a_q) begin
        out_d     = lvl_q;
        busy_d    = 1'b0;
        pulse_end = 1'b1;
      end
    end
    if (wrap_evt) begin
      hold_d = 1'b1;
    end else if (cnt_d != CNT_ZERO) begin
      // Guard drops as the count steps to one, so a clear there works
      hold_d = 1'b0;
    end
    // Set wins over clear, and a clear before count one is void
    ovf_d = wrap_evt || (ovf_q && (!overflow_clear || hold_q));         // see RULE16
    if (cap_a_evt) begin
      cap_a_d             = cnt_q;
      irq_d.capcomp_irq_a = eb.valid;                                     // see RULE10
    end else if (wr_a && !cap_mode_a) begin
      cap_a_d = wr_data;
    end
    if (cap_b_evt) begin
      cap_b_d             = cnt_q;
      irq_d.capcomp_irq_b = 1'b1;
    end else if (wr_b && !cap_mode_b) begin
      cap_b_d = wr_data;
    end
    if (rd_a || rd_b) begin
      rd_d   = rd_a ? cap_a_q : cap_b_q;
      // Capture still happens; the colliding read is flagged unusable
      rdok_d = !((rd_a && cap_a_evt) || (!rd_a && cap_b_evt));          // see RULE9
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q   <= CNT_ZERO;
      cap_a_q <= CNT_ZERO;
      cap_b_q <= CNT_ZERO;
      ovf_q   <= 1'b0;
      hold_q  <= 1'b0;
      busy_q  <= 1'b0;
      out_q   <= 1'b0;
      lvl_q   <= 1'b0;
      irq_q   <= '0;
      rd_q    <= CNT_ZERO;
      rdok_q  <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      cap_a_q <= cap_a_d;
      cap_b_q <= cap_b_d;
      ovf_q   <= ovf_d;
      hold_q  <= hold_d;
      busy_q  <= busy_d;
      out_q   <= out_d;
      lvl_q   <= lvl_d;
      irq_q   <= irq_d;
      rd_q    <= rd_d;
      rdok_q  <= rdok_d;
    end
  end

  assign count_value_reg = cnt_q;
  assign rd_data         = rd_q;
  assign rd_ok           = rdok_q;
  assign overflow_flag   = ovf_q;
  assign irq             = irq_q;
  assign oneshot_out     = out_q;
  assign oneshot_busy    = busy_q;

  // ****************
  // Assertions
  // ****************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  property p_stop_zero;
    mode == MODE_STOP |=> cnt_q == CNT_ZERO;
  endproperty
  a_stop_zero: assert property (p_stop_zero) else $error("counter not held at zero while stopped"); // see RULE3

  property p_count_up;
    tick && mode == MODE_FREE && !os_start |=> cnt_q == 16'($past(cnt_q) + CNT_ONE);
  endproperty
  a_count_up: assert property (p_count_up) else $error("free counter did not advance by one"); // see RULE19

  property p_ovf_set;
    tick && cnt_q == CNT_MAX && mode != MODE_STOP && !os_start && !trig_clr |=> ovf_q ##1 ovf_q;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set on wrap"); // see RULE15

  property p_ovf_hold;
    ovf_q && hold_q && overflow_clear |=> ovf_q;
  endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("overflow clear took effect before count one"); // see RULE16

  property p_ignore;
    busy_q && ea.valid && !tick && mode != MODE_STOP |=> busy_q && cnt_q == $past(cnt_q);
  endproperty
  a_ignore: assert property (p_ignore) else $error("trigger disturbed running pulse"); // see RULE4

  property p_trig_clr;
    mode == MODE_TRIG_CLR && ea.valid && !busy_q |=> cnt_q == CNT_ZERO;
  endproperty
  a_trig_clr: assert property (p_trig_clr) else $error("trigger edge did not clear counter"); // see RULE1

  property p_no_os_match;
    mode == MODE_MATCH_CLR |-> !os_start;
  endproperty
  a_no_os_match: assert property (p_no_os_match) else $error("one-shot started in match clear mode"); // see RULE17

  property p_ext_channel;
    CHANNEL_ID != 1'b0 |-> !os_ext;
  endproperty
  a_ext_channel: assert property (p_ext_channel) else $error("external one-shot on wrong channel"); // see RULE5

  property p_cap_irq;
    cap_a_evt && eb.valid |=> irq.capcomp_irq_a && cap_a_q == $past(cnt_q);
  endproperty
  a_cap_irq: assert property (p_cap_irq) else $error("valid edge capture lacks interrupt"); // see RULE10

  property p_rev_silent;
    cap_a_evt && !eb.valid |=> !irq.capcomp_irq_a;
  endproperty
  a_rev_silent: assert property (p_rev_silent) else $error("reverse edge raised interrupt"); // see RULE10

  property p_rd_clash;
    rd_a && cap_a_evt |=> !rd_ok;
  endproperty
  a_rd_clash: assert property (p_rd_clash) else $error("colliding read flagged good"); // see RULE9

  property p_match_clr;
    tick && mode == MODE_MATCH_CLR && cnt_q == cap_a_q && !trig_clr |=> cnt_q == CNT_ZERO;
  endproperty
  a_match_clr: assert property (p_match_clr) else $error("match did not clear counter"); // see RULE8

  c_ovf:   cover property (wrap_evt ##1 ovf_q);
  c_pulse: cover property (os_start ##[1:1000] pulse_end);
  c_cap:   cover property (cap_b_evt ##1 irq.capcomp_irq_b);
endmodule
